// ==== gtm_consts.svh ====
/*
 * Constants for the general timer: register offsets, field positions,
 * reset values and divider ratios.
 * Assumes inclusion by its bare name; the guard allows several includers.
 */
`ifndef GTM_CONSTS_SVH
`define GTM_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define GTM_ADDR_W          8
`define GTM_CTRL_OFS        8'h04
`define GTM_COUNT_OFS       8'h08
`define GTM_COMPARE_OFS     8'h0C
`define GTM_CLKCFG_OFS      8'h10
`define GTM_IRQ_OFS         8'h14

////////////////////////////////////////////////////////////////////////////////
// field positions
`define GTM_CTRL_TRIG_LSB   0
`define GTM_CTRL_METHOD_LSB 2
`define GTM_CTRL_CLEAR_BIT  4
`define GTM_CTRL_ENABLE_BIT 5
`define GTM_CLK_DIV_LSB     4
`define GTM_CLK_GATE_BIT    6
`define GTM_CLK_SRC_BIT     7
`define GTM_IRQ_GIE_BIT     0
`define GTM_IRQ_FLAG_BIT    1
`define GTM_IRQ_IE_BIT      17

////////////////////////////////////////////////////////////////////////////////
// reset values
`define GTM_COMPARE_RST     16'hFFFF
`define GTM_COUNT_RST       16'h0000

////////////////////////////////////////////////////////////////////////////////
// source edges per divided tick, by divider field
`define GTM_DIV_RATIO0      5'h02
`define GTM_DIV_RATIO1      5'h04
`define GTM_DIV_RATIO2      5'h08
`define GTM_DIV_RATIO3      5'h10

////////////////////////////////////////////////////////////////////////////////
// axi responses
`define GTM_RESP_OKAY       2'h0
`define GTM_RESP_SLVERR     2'h2

`endif

// ==== gtm_pkg.sv ====
/*
 * Types of the general timer: counting methods and trigger sources.
 * Assumes gtm_consts.svh is on the include path.
 */
`include "gtm_consts.svh"

package gtm_pkg;

   typedef enum logic [1:0] {
      GTM_M_WRAP,
      GTM_M_UPDOWN,
      GTM_M_SPLIT,
      GTM_M_CASCADE
   } gtm_method_e;

   typedef enum logic [1:0] {
      GTM_T_ALWAYS,
      GTM_T_COMPARATOR,
      GTM_T_OPAMP,
      GTM_T_CAPTURE
   } gtm_trigger_e;

   typedef logic [15:0] gtm_count_t;

endpackage

// ==== gtm_tick_if.sv ====
/*
 * Carrier between the timer core and its tick divider.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/100ps

interface gtm_tick_if;
   logic       tick_source_sel;
   logic       tick_divider_gate;
   logic [1:0] tick_divider_sel;
   logic       divided_tick;

   modport core    (output tick_source_sel, output tick_divider_gate, output tick_divider_sel,
                    input divided_tick);
   modport divider (input tick_source_sel, input tick_divider_gate, input tick_divider_sel,
                    output divided_tick);
endinterface

// ==== gtm_divider.sv ====
/*
 * Tick divider: synchronises both source clocks, picks one, counts its
 * rising edges and pulses divided_tick for one clk_i cycle every ratio edges.
 * Assumes source clocks are much slower than clk_i (under clk_i/4).
 */
`timescale 1ns/100ps
`include "gtm_consts.svh"

module gtm_divider (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic reset_i,
   // source clock pins
   input  wire logic fast_source_clock_i,
   input  wire logic slow_source_clock_i,
   // core side
   gtm_tick_if.divider tick_if
);
   import gtm_pkg::*;

   logic [1:0] fast_sync_q;
   logic [1:0] slow_sync_q;
   logic       src_last_q;
   logic [4:0] edge_cnt_q;
   logic [4:0] ratio;
   logic       src_lvl;
   logic       src_rise;
   logic       tick_q;

   ////////////////////////////////////////////////////////////////////////////
   // two-stage synchronisers
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         fast_sync_q <= 2'h0;
         slow_sync_q <= 2'h0;
      end else begin
         fast_sync_q <= {fast_sync_q[0], fast_source_clock_i};
         slow_sync_q <= {slow_sync_q[0], slow_source_clock_i};
      end
   end

   assign src_lvl  = tick_if.tick_source_sel ? slow_sync_q[1] : fast_sync_q[1];
   assign src_rise = src_lvl & ~src_last_q;

   always_comb begin
      unique case (tick_if.tick_divider_sel)
         2'h0: ratio = `GTM_DIV_RATIO0;
         2'h1: ratio = `GTM_DIV_RATIO1;
         2'h2: ratio = `GTM_DIV_RATIO2;
         2'h3: ratio = `GTM_DIV_RATIO3;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // edge counter; a gated divider holds its count at zero
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         src_last_q <= 1'b0;
         edge_cnt_q <= 5'h00;
         tick_q     <= 1'b0;
      end else begin
         src_last_q <= src_lvl;
         tick_q     <= 1'b0;
         if (!tick_if.tick_divider_gate) begin
            edge_cnt_q <= 5'h00;
         end else if (src_rise) begin
            if (edge_cnt_q >= ratio - 5'h01) begin
               edge_cnt_q <= 5'h00;
               tick_q     <= 1'b1;
            end else begin
               edge_cnt_q <= edge_cnt_q + 5'h01;
            end
         end
      end
   end

   assign tick_if.divided_tick = tick_q;

endmodule

// ==== gtm_top.sv ====
/*
 * General timer top: AXI4-Lite register slave, 16-bit counter with four
 * counting methods, trigger gating, overflow flag and interrupt request.
 * Assumes trigger and source clock pins are asynchronous to clk_i and
 * that one write and one read at most are outstanding.
 */
`timescale 1ns/100ps
`include "gtm_consts.svh"

module gtm_top (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   // axi4-lite write address
   input  wire logic [7:0]  s_axi_awaddr_i,
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp_o,
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   // axi4-lite read address
   input  wire logic [7:0]  s_axi_araddr_i,
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   // axi4-lite read data
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   // source clocks and trigger pins
   input  wire logic        fast_source_clock_i,
   input  wire logic        slow_source_clock_i,
   input  wire logic        comparator_out_i,
   input  wire logic        opamp_out_i,
   input  wire logic        capture_timer_out_i,
   // power state
   input  wire logic        sleep_mode_i,
   // interrupt
   output logic             overflow_irq_o,
   output logic             wake_o
);
   import gtm_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   gtm_tick_if tick_if ();

   logic             awready_q;
   logic             wready_q;
   logic             aw_held_q;
   logic             w_held_q;
   logic [7:0]       waddr_q;
   logic [31:0]      wdata_q;
   logic [3:0]       wstrb_q;
   logic             bvalid_q;
   logic [1:0]       bresp_q;
   logic             arready_q;
   logic             rvalid_q;
   logic [31:0]      rdata_q;
   logic [1:0]       rresp_q;

   logic             do_write;
   logic [31:0]      wr_data;
   logic [3:0]       wr_strb;
   logic [7:0]       wr_addr;
   logic             wr_ctrl;
   logic             wr_compare;
   logic             wr_clkcfg;
   logic             wr_irq;
   logic             wr_mapped;
   logic [31:0]      rd_word;
   logic             rd_mapped;

   logic [1:0]       trig_sel_q;
   logic [1:0]       method_q;
   logic             clear_q;
   logic             enable_q;
   gtm_count_t       compare_q;
   logic             src_sel_q;
   logic             gate_q;
   logic [1:0]       div_sel_q;
   logic             gie_q;
   logic             ie_q;
   logic             flag_q;
   logic             irq_q;
   logic             wake_q;

   logic [1:0]       cmp_sync_q;
   logic [1:0]       opa_sync_q;
   logic [1:0]       cap_sync_q;
   logic             trig_ok;

   gtm_count_t       count_q;
   gtm_count_t       count_d;
   logic             down_q;
   logic             down_d;
   logic             ovf;
   logic             step;
   logic [7:0]       lo;
   logic [7:0]       hi;
   gtm_method_e      method;
   gtm_trigger_e     trigger;

   ////////////////////////////////////////////////////////////////////////////
   // axi write channels: address and data taken in either order
   assign wr_addr  = aw_held_q ? waddr_q : s_axi_awaddr_i;
   assign wr_data  = w_held_q ? wdata_q : s_axi_wdata_i;
   assign wr_strb  = w_held_q ? wstrb_q : s_axi_wstrb_i;
   assign do_write = (aw_held_q | (s_axi_awvalid_i & awready_q)) &
                     (w_held_q | (s_axi_wvalid_i & wready_q));

   assign wr_ctrl    = do_write & (wr_addr == `GTM_CTRL_OFS);
   assign wr_compare = do_write & (wr_addr == `GTM_COMPARE_OFS);
   assign wr_clkcfg  = do_write & (wr_addr == `GTM_CLKCFG_OFS);
   assign wr_irq     = do_write & (wr_addr == `GTM_IRQ_OFS);
   assign wr_mapped  = wr_ctrl | wr_compare | wr_clkcfg | wr_irq | (wr_addr == `GTM_COUNT_OFS);

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         waddr_q   <= 8'h00;
         wdata_q   <= 32'h00000000;
         wstrb_q   <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `GTM_RESP_OKAY;
      end else begin
         if (do_write) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_mapped ? `GTM_RESP_OKAY : `GTM_RESP_SLVERR;
         end else begin
            if (s_axi_awvalid_i && awready_q) begin
               aw_held_q <= 1'b1;
               waddr_q   <= s_axi_awaddr_i;
               awready_q <= 1'b0;
            end
            if (s_axi_wvalid_i && wready_q) begin
               w_held_q <= 1'b1;
               wdata_q  <= s_axi_wdata_i;
               wstrb_q  <= s_axi_wstrb_i;
               wready_q <= 1'b0;
            end
            if (bvalid_q && s_axi_bready_i) begin
               bvalid_q  <= 1'b0;
               awready_q <= 1'b1;
               wready_q  <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi read channel: answer one cycle after the address is taken
   always_comb begin
      rd_word   = 32'h00000000;
      rd_mapped = 1'b1;
      unique case (s_axi_araddr_i)
         `GTM_CTRL_OFS: begin
            rd_word[`GTM_CTRL_TRIG_LSB +: 2]   = trig_sel_q;
            rd_word[`GTM_CTRL_METHOD_LSB +: 2] = method_q;
            rd_word[`GTM_CTRL_CLEAR_BIT]       = clear_q;
            rd_word[`GTM_CTRL_ENABLE_BIT]      = enable_q;
         end
         `GTM_COUNT_OFS:   rd_word[15:0] = count_q;
         `GTM_COMPARE_OFS: rd_word[15:0] = compare_q;
         `GTM_CLKCFG_OFS: begin
            rd_word[`GTM_CLK_DIV_LSB +: 2] = div_sel_q;
            rd_word[`GTM_CLK_GATE_BIT]     = gate_q;
            rd_word[`GTM_CLK_SRC_BIT]      = src_sel_q;
         end
         `GTM_IRQ_OFS: begin
            rd_word[`GTM_IRQ_GIE_BIT]  = gie_q;
            rd_word[`GTM_IRQ_FLAG_BIT] = flag_q;
            rd_word[`GTM_IRQ_IE_BIT]   = ie_q;
         end
         default: rd_mapped = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h00000000;
         rresp_q   <= `GTM_RESP_OKAY;
      end else if (s_axi_arvalid_i && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= rd_word;
         rresp_q   <= rd_mapped ? `GTM_RESP_OKAY : `GTM_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready_i) begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control and configuration registers
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         trig_sel_q <= 2'h0;
         method_q   <= 2'h0;
         enable_q   <= 1'b0;
         compare_q  <= `GTM_COMPARE_RST;
         src_sel_q  <= 1'b0;
         gate_q     <= 1'b0;
         div_sel_q  <= 2'h0;
         gie_q      <= 1'b0;
         ie_q       <= 1'b0;
      end else begin
         if (wr_ctrl && wr_strb[0]) begin
            trig_sel_q <= wr_data[`GTM_CTRL_TRIG_LSB +: 2];
            method_q   <= wr_data[`GTM_CTRL_METHOD_LSB +: 2];
            enable_q   <= wr_data[`GTM_CTRL_ENABLE_BIT];
         end
         if (wr_compare && wr_strb[0]) begin
            compare_q[7:0] <= wr_data[7:0];
         end
         if (wr_compare && wr_strb[1]) begin
            compare_q[15:8] <= wr_data[15:8];
         end
         if (wr_clkcfg && wr_strb[0]) begin
            div_sel_q <= wr_data[`GTM_CLK_DIV_LSB +: 2];
            gate_q    <= wr_data[`GTM_CLK_GATE_BIT];
            src_sel_q <= wr_data[`GTM_CLK_SRC_BIT];
         end
         if (wr_irq && wr_strb[0]) begin
            gie_q <= wr_data[`GTM_IRQ_GIE_BIT];
         end
         if (wr_irq && wr_strb[2]) begin
            ie_q <= wr_data[`GTM_IRQ_IE_BIT];
         end
      end
   end

   // clear bit lives one cycle, so a read right after the write may see it
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         clear_q <= 1'b0;
      end else begin
         clear_q <= wr_ctrl & wr_strb[0] & wr_data[`GTM_CTRL_CLEAR_BIT];
      end
   end

   assign tick_if.tick_source_sel   = src_sel_q;
   assign tick_if.tick_divider_gate = gate_q;
   assign tick_if.tick_divider_sel  = div_sel_q;

   gtm_divider gtm_divider_i (
      .clk_i               (clk_i),
      .reset_i             (reset_i),
      .fast_source_clock_i (fast_source_clock_i),
      .slow_source_clock_i (slow_source_clock_i),
      .tick_if             (tick_if)
   );

   ////////////////////////////////////////////////////////////////////////////
   // trigger pins: two flops before any use
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cmp_sync_q <= 2'h0;
         opa_sync_q <= 2'h0;
         cap_sync_q <= 2'h0;
      end else begin
         cmp_sync_q <= {cmp_sync_q[0], comparator_out_i};
         opa_sync_q <= {opa_sync_q[0], opamp_out_i};
         cap_sync_q <= {cap_sync_q[0], capture_timer_out_i};
      end
   end

   assign trigger = gtm_trigger_e'(trig_sel_q);

   always_comb begin
      unique case (trigger)
         GTM_T_ALWAYS:     trig_ok = 1'b1;
         GTM_T_COMPARATOR: trig_ok = cmp_sync_q[1];
         GTM_T_OPAMP:      trig_ok = opa_sync_q[1];
         GTM_T_CAPTURE:    trig_ok = cap_sync_q[1];
      endcase
   end

   // sleep stops the count; idle, wait and standby keep it running
   assign step   = tick_if.divided_tick & enable_q & trig_ok & ~sleep_mode_i;
   assign method = gtm_method_e'(method_q);
   assign lo     = count_q[7:0];
   assign hi     = count_q[15:8];

   ////////////////////////////////////////////////////////////////////////////
   // counting methods
   always_comb begin
      count_d = count_q;
      down_d  = down_q;
      ovf     = 1'b0;
      unique case (method)
         GTM_M_WRAP: begin
            down_d = 1'b0;
            if (count_q >= compare_q) begin
               count_d = `GTM_COUNT_RST;
               ovf     = 1'b1;
            end else begin
               count_d = count_q + 16'h0001;
            end
         end
         GTM_M_UPDOWN: begin
            if (!down_q) begin
               if (compare_q == 16'h0000) begin
                  count_d = `GTM_COUNT_RST;
                  ovf     = 1'b1;
               end else if (count_q >= compare_q) begin
                  count_d = count_q - 16'h0001;
                  down_d  = 1'b1;
               end else begin
                  count_d = count_q + 16'h0001;
               end
            end else begin
               count_d = count_q - 16'h0001;
               if (count_q <= 16'h0001) begin
                  count_d = `GTM_COUNT_RST;
                  down_d  = 1'b0;
                  ovf     = 1'b1;
               end
            end
         end
         GTM_M_SPLIT: begin
            down_d = 1'b0;
            count_d[15:8] = (hi >= compare_q[15:8]) ? 8'h00 : hi + 8'h01;
            count_d[7:0]  = (lo >= compare_q[7:0]) ? 8'h00 : lo + 8'h01;
            ovf           = (lo >= compare_q[7:0]);
         end
         GTM_M_CASCADE: begin
            down_d = 1'b0;
            if (lo >= compare_q[7:0]) begin
               count_d[7:0]  = 8'h00;
               count_d[15:8] = hi + 8'h01;
               ovf           = 1'b1;
            end else begin
               count_d[7:0] = lo + 8'h01;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         count_q <= `GTM_COUNT_RST;
         down_q  <= 1'b0;
      end else if (clear_q) begin
         count_q <= `GTM_COUNT_RST;
         down_q  <= 1'b0;
      end else if (step) begin
         count_q <= count_d;
         down_q  <= down_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // overflow flag and interrupt; a set in the same cycle beats a clear
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         flag_q <= 1'b0;
      end else if (step && ovf && !clear_q) begin
         flag_q <= 1'b1;
      end else if (wr_irq && wr_strb[0] && !wr_data[`GTM_IRQ_FLAG_BIT]) begin
         flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         irq_q  <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         irq_q  <= flag_q & ie_q & gie_q;
         wake_q <= flag_q & ie_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign s_axi_awready_o = awready_q;
   assign s_axi_wready_o  = wready_q;
   assign s_axi_bvalid_o  = bvalid_q;
   assign s_axi_bresp_o   = bresp_q;
   assign s_axi_arready_o = arready_q;
   assign s_axi_rvalid_o  = rvalid_q;
   assign s_axi_rdata_o   = rdata_q;
   assign s_axi_rresp_o   = rresp_q;
   assign overflow_irq_o  = irq_q;
   assign wake_o          = wake_q;

endmodule

// ==== gtm_top_assertions.sv ====
/*
 * Checker for the general timer top: bus answers and interrupt outputs.
 * Assumes one clock domain and the synchronous active-high reset.
 */
`timescale 1ns/100ps

module gtm_chk (
   // clock and reset
   input wire logic       clk_i,
   input wire logic       reset_i,
   // bus
   input wire logic       s_axi_awvalid_i,
   input wire logic       s_axi_awready_o,
   input wire logic       s_axi_wvalid_i,
   input wire logic       s_axi_wready_o,
   input wire logic       s_axi_bvalid_o,
   input wire logic       s_axi_bready_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic       s_axi_arvalid_i,
   input wire logic       s_axi_arready_o,
   input wire logic [1:0] s_axi_rresp_o,
   input wire logic       s_axi_rvalid_o,
   input wire logic       s_axi_rready_i,
   // interrupt
   input wire logic       overflow_irq_o,
   input wire logic       wake_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   sequence s_aw;
      s_axi_awvalid_i && s_axi_awready_o;
   endsequence
   sequence s_ar;
      s_axi_arvalid_i && s_axi_arready_o;
   endsequence
   a_write_answer: assert property (s_aw ##0 (s_axi_wvalid_i && s_axi_wready_o) |=> s_axi_bvalid_o && !s_axi_awready_o)
      else $error("write not answered");
   a_bvalid_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
      else $error("write answer dropped");
   a_read_answer: assert property (s_ar |=> s_axi_rvalid_o && !s_axi_arready_o)
      else $error("read not answered");
   a_rresp_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rresp_o))
      else $error("read answer dropped");
   a_unmapped_read: assert property (s_ar ##0 (s_axi_araddr_i == 8'h20) |=> s_axi_rresp_o == 2'h2)
      else $error("unmapped read not refused");
   a_irq_gated: assert property (overflow_irq_o |-> wake_o)
      else $error("irq without flag and enable");
   // a write may land on the edge of either channel, so both are excluded
   a_flag_sticky: assert property (wake_o && !s_axi_wvalid_i && !s_axi_awvalid_i && !$past(s_axi_wvalid_i)
      && !$past(s_axi_awvalid_i) |=> wake_o) else $error("flag lost without write");
   a_reset_values: assert property ($fell(reset_i) |-> !overflow_irq_o && !wake_o && s_axi_awready_o)
      else $error("bad state after reset");
endmodule

bind gtm_top gtm_chk gtm_chk_i (.clk_i(clk_i), .reset_i(reset_i), .s_axi_awvalid_i(s_axi_awvalid_i),
   .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
   .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
   .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o), .s_axi_rresp_o(s_axi_rresp_o),
   .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i), .overflow_irq_o(overflow_irq_o),
   .wake_o(wake_o));

// ==== gtm_tb_top.sv ====
/*
 * Self-checking bench for the general timer top.
 * Assumes the checker is bound to gtm_top and source clocks under clk/4.
 */
`timescale 1ns/100ps

module gtm_tb_top;
   logic        clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, irq, wake;
   logic [1:0]  bresp, rresp;
   logic [3:0]  div = 4'h0;
   logic [2:0]  trig = 3'h0;
   logic        sleep = 1'b0;
   int          n_fail = 0, checked = 0;
   always #2 clk_i = ~clk_i;
   // source clocks of 8 and 16 cycles
   always @(posedge clk_i) div <= div + 4'h1;
   gtm_top gtm_top_i (.clk_i(clk_i), .reset_i(reset_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .fast_source_clock_i(div[2]),
      .slow_source_clock_i(div[3]), .comparator_out_i(trig[0]), .opamp_out_i(trig[1]),
      .capture_timer_out_i(trig[2]),
      .sleep_mode_i(sleep), .overflow_irq_o(irq), .wake_o(wake));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         $display("[ERR] %s exp %h got %h", nm, e, g);
         n_fail++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int i;
      @(posedge clk_i);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      for (i = 0; i < 100 && !(bvalid && bready); i++) begin
         @(posedge clk_i);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      chk("bresp", er, bresp);
      if (i == 100) begin
         $display("[ERR] bvalid wait exp 1 got 0");
         n_fail++;
         final_report();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
      int i;
      @(posedge clk_i);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (i = 0; i < 100 && !(rvalid && rready); i++) begin
         @(posedge clk_i);
         if (arready) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      d = rdata;
      chk("rresp", er, rresp);
      if (i == 100) begin
         $display("[ERR] rvalid wait exp 1 got 0");
         n_fail++;
         final_report();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [31:0] d;
      rd(8'h0C, 2'h0, d); chk("compare", 32'hFFFF, d);
      rd(8'h04, 2'h0, d); chk("ctrl", 32'h0, d);
      wr(8'h08, 32'h55, 2'h0); rd(8'h08, 2'h0, d); chk("count", 32'h0, d);
      wr(8'h20, 32'h1, 2'h2); rd(8'h20, 2'h2, d); chk("unmapped", 32'h0, d);
   endtask
   task automatic t_methods();
      logic [31:0] c, d;
      wr(8'h10, 32'h40, 2'h0); wr(8'h0C, 32'h3, 2'h0);
      for (int m = 0; m < 4; m++) begin
         wr(8'h04, 32'h10 | (m << 2), 2'h0); rd(8'h08, 2'h0, d); chk("cleared", 32'h0, d);
         rd(8'h04, 2'h0, d); chk("ctrl", m << 2, d);
         wr(8'h14, 32'h20001, 2'h0); repeat (3) @(posedge clk_i); chk("irq off", 32'h0, irq);
         wr(8'h04, 32'h20 | (m << 2), 2'h0); repeat (300) @(posedge clk_i);
         wr(8'h04, m << 2, 2'h0); rd(8'h08, 2'h0, c);
         chk("low in range", 32'h1, c[7:0] <= 8'h03);
         chk("high moves", m == 3, c[15:8] != 8'h00);
         rd(8'h14, 2'h0, d); chk("flag", 32'h20003, d); chk("irq", 32'h1, irq);
         repeat (100) @(posedge clk_i); rd(8'h08, 2'h0, d); chk("stopped", c, d);
      end
   endtask
   task automatic t_gate();
      logic [31:0] c, d;
      wr(8'h0C, 32'hFFFF, 2'h0);
      for (int t = 1; t < 4; t++) begin
         // only the selected source is low, so a wrong pick would count
         trig <= ~(3'h1 << (t - 1)); sleep <= 1'b0; wr(8'h04, 32'h10, 2'h0); wr(8'h04, 32'h20 | t, 2'h0);
         repeat (150) @(posedge clk_i); rd(8'h08, 2'h0, d); chk("gated", 32'h0, d);
         trig <= 3'h1 << (t - 1); repeat (150) @(posedge clk_i); rd(8'h08, 2'h0, c);
         chk("counting", 32'h1, c != 32'h0);
         sleep <= 1'b1; repeat (20) @(posedge clk_i); rd(8'h08, 2'h0, c);
         repeat (100) @(posedge clk_i); rd(8'h08, 2'h0, d); chk("asleep", c, d);
      end
   endtask
   // flag is still set from the method runs; reset must drop it mid-run
   task automatic t_midreset();
      logic [31:0] d;
      wr(8'h14, 32'h20002, 2'h0); repeat (3) @(posedge clk_i);
      chk("irq no gie", 32'h0, irq); chk("wake", 32'h1, wake);
      reset_i <= 1'b1; repeat (3) @(posedge clk_i); reset_i <= 1'b0;
      chk("irq reset", 32'h0, irq); chk("wake reset", 32'h0, wake);
      rd(8'h14, 2'h0, d); chk("irq reg reset", 32'h0, d);
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      reset_i <= 1'b0;
      t_reset();
      t_methods();
      t_gate();
      t_midreset();
      final_report();
   end
endmodule
